// File: shared/fail_safe_monitor_params.svh
// Constants of the fail-safe clock monitor.
// Assumes one system clock of 125 MHz; included by the monitor files.
// Function
// - Enable monitor only when fuse bit six set.
// - Keep internal RC running while monitor enabled.
// - Sample clock is internal RC divided by 64.
// - Latch set on monitored fall, cleared sample rise.
// - Failure when sample falls with latch set.
// - Failure sets oscillator fail flag, bit seven.
// - Failure switches clock internal; control register untouched.
// - Failure clears watchdog counter and postscaler.
// - Only primary and secondary sources are checked.
// - Watchdog disable never stops RC under monitor.
// - Fail-safe ends only on reset or sleep.
// - After reset start primary, then switch, resume.
// - Primary never ready: stay on internal clock.
// - Sleep entry selects control register source, monitors.
// - Failure asleep with interrupt enabled wakes, internal.
// - Failure asleep, interrupt off: stay, clock internal.
// - Non-crystal modes monitor immediately after reset.
// - Crystal modes wait start-up timers before monitoring.
// - Crystal never starting raises no fail flag.
// - Sleep entry while waiting disables primary clock.
// - Sample period scales with internal RC tuning.
// - Ready bit high only while primary clocks system.
`ifndef FAIL_SAFE_MONITOR_PARAMS_SVH
`define FAIL_SAFE_MONITOR_PARAMS_SVH
// Clock period of clk_sys in nanoseconds.
`define FAIL_SAFE_MONITOR_CLK_PERIOD_NS 8
// Division from internal RC to sample clock.
`define FAIL_SAFE_MONITOR_SAMPLE_DIV 64
// Width of the sample divider counter.
`define FAIL_SAFE_MONITOR_DIV_W 6
// Fuse bit in configuration word 1 high.
`define FAIL_SAFE_MONITOR_FUSE_BIT 6
// Flag bit in peripheral interrupt flags 2.
`define FAIL_SAFE_MONITOR_FLAG_BIT 7
// Ready bit in the oscillator control register.
`define FAIL_SAFE_MONITOR_READY_BIT 3
`endif

// File: shared/fail_safe_monitor_pkg.sv
// Types of the fail-safe clock monitor.
// Assumes the constants header is available to its users.
package fail_safe_monitor_pkg;
  // Top-level sequence of the clock switch.
  typedef enum logic [1:0] {ST_STARTUP, ST_MONITOR, ST_FAILSAFE} fail_safe_monitor_state_t;
  // System clock sources as the clock multiplexer knows them.
  typedef enum logic [1:0] {SEL_PRIMARY, SEL_SECONDARY, SEL_INTERNAL} fail_safe_monitor_sel_t;
  // Primary oscillator modes from configuration word 1 high.
  typedef enum logic [2:0] {
    MD_LOW_PWR_XTAL, MD_STD_XTAL, MD_FAST_XTAL, MD_FAST_XTAL_PLL,
    MD_EXT_CLOCK, MD_EXT_RES_CAP, MD_INT_OSC
  } fail_safe_monitor_mode_t;
endpackage

// File: rtl/fail_safe_monitor_sync.sv
// Two-flop synchroniser with rise and fall pulses.
// Assumes its input is asynchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module fail_safe_monitor_sync
  import fail_safe_monitor_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic pin_async,
  output logic      level_sync,
  output logic      rise_pls,
  output logic      fall_pls
);
  // Whole state of the synchroniser.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } fail_safe_monitor_sync_t;
  fail_safe_monitor_sync_t st_r;
  fail_safe_monitor_sync_t st_nxt;

  // The first stage feeds only the second; edges use stages two and three.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  // Registers the state on every rising edge of clk_sys.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_sync = st_r.s2;
  assign rise_pls   = st_r.s2 & ~st_r.s3;
  assign fall_pls   = ~st_r.s2 & st_r.s3;
endmodule // fail_safe_monitor_sync
`default_nettype wire

// File: rtl/fail_safe_monitor_sample_div.sv
// Divider that turns internal RC edges into sample clock edges.
// Assumes one rc_rise pulse per internal RC period, in clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "fail_safe_monitor_params.svh"
module fail_safe_monitor_sample_div
  import fail_safe_monitor_pkg::*;
#(
  parameter int DIV_W = `FAIL_SAFE_MONITOR_DIV_W
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic rc_rise,
  output logic      smp_rise,
  output logic      smp_fall
);
  // Whole state: counter and registered edge pulses.
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             rise;
    logic             fall;
  } fail_safe_monitor_div_t;
  fail_safe_monitor_div_t st_r;
  fail_safe_monitor_div_t st_nxt;

  // The sample clock is the counter top bit, so one period is 2**DIV_W.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    if (rc_rise) begin
      st_nxt.cnt  = DIV_W'(st_r.cnt + 1'b1);
      st_nxt.rise = ~st_r.cnt[DIV_W-1] & (&st_r.cnt[DIV_W-2:0]);
      st_nxt.fall = &st_r.cnt;
    end
  end

  // Reset restarts the sample period from zero.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign smp_rise = st_r.rise;
  assign smp_fall = st_r.fall;
endmodule // fail_safe_monitor_sample_div
`default_nettype wire

// File: rtl/fail_safe_monitor_monitor.sv
// Fail-safe clock monitor: clock checking and fail-safe clock switch.
// Assumes clocks arrive as pins and oscillator control bits as ports.
`timescale 1ns/10ps
`default_nettype none
`include "fail_safe_monitor_params.svh"
module fail_safe_monitor_monitor
  import fail_safe_monitor_pkg::*;
(
  input  wire logic       clk_sys,              // System clock, 125 MHz.
  input  wire logic       srst,                 // Synchronous reset, high.
  input  wire logic [7:0] config_word_1_high,   // Configuration fuses.
  input  wire logic [2:0] primary_mode,         // Primary oscillator mode.
  input  wire logic       mon_clk_pin,          // Monitored system clock.
  input  wire logic       rc_clk_pin,           // Internal RC oscillator.
  input  wire logic       startup_done,         // Start-up timers expired.
  input  wire logic       wake_from_sleep,      // Wake pulse, restart.
  input  wire logic       pm_entry,             // Sleep executed, pulse.
  input  wire logic [1:0] osc_ctrl_sel,         // Source held in control.
  input  wire logic       in_power_managed,     // Device in a sleep mode.
  input  wire logic       osc_fail_irq_en,      // Fail interrupt enable.
  input  wire logic       osc_fail_flag_clr,    // Software flag clear.
  input  wire logic       watchdog_enable,      // Watchdog wants RC.
  output logic            rc_run_en,            // Keep internal RC on.
  output logic [1:0]      sys_clk_sel,          // Actual clock source.
  output logic            primary_osc_en,       // Primary oscillator on.
  output logic            primary_ready_status, // Primary clocks system.
  output logic            osc_fail_flag,        // Sticky fail flag.
  output logic [7:0]      peripheral_irq_flags_2, // Flag in its bit.
  output logic            watchdog_clear,       // Watchdog clear pulse.
  output logic            fail_safe_active,     // Fail-safe condition.
  output logic            pm_wake_req           // Wake the CPU, pulse.
);

  ////////////////////////////////////////////////////////////////////////
  // Types and state.
  ////////////////////////////////////////////////////////////////////////

  // Whole state of the monitor.
  typedef struct packed {
    fail_safe_monitor_state_t fsm;      // Sequence state.
    fail_safe_monitor_sel_t   sel;      // Source driving the system clock.
    logic        latch;    // Clock monitor latch.
    logic        flag;     // Oscillator fail flag.
    logic        wdt_clr;  // Watchdog clear pulse.
    logic        wake;     // CPU wake pulse.
    logic        prim_en;  // Primary oscillator enable.
  } fail_safe_monitor_mon_t;

  fail_safe_monitor_mon_t st_r;    // Registered state.
  fail_safe_monitor_mon_t st_nxt;  // Next state.

  logic mon_fall;     // Falling edge of monitored clock.
  logic rc_rise;      // Rising edge of internal RC.
  logic smp_rise;     // Rising edge of sample clock.
  logic smp_fall;     // Falling edge of sample clock.
  logic fuse_en;      // Monitor enabled by the fuse.
  logic mon_active;   // Monitoring in force this cycle.
  logic clk_fail;     // Failure detected this cycle.

  ////////////////////////////////////////////////////////////////////////
  // Functions.
  ////////////////////////////////////////////////////////////////////////

  // True for modes that need a crystal start-up delay.
  function automatic logic is_crystal(input logic [2:0] mode);
    logic res;
    res = 1'b0;
    if (mode == MD_LOW_PWR_XTAL || mode == MD_STD_XTAL ||
        mode == MD_FAST_XTAL || mode == MD_FAST_XTAL_PLL) begin
      res = 1'b1;
    end
    return res;
  endfunction

  // True for sources that the monitor is able to check.
  function automatic logic is_checked(input fail_safe_monitor_sel_t sel);
    return (sel == SEL_PRIMARY) || (sel == SEL_SECONDARY);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and sample clock.
  ////////////////////////////////////////////////////////////////////////

  // Monitored clock; only its falling edge matters.
  fail_safe_monitor_sync u_sync_mon (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .pin_async  (mon_clk_pin),
    .level_sync (),
    .rise_pls   (),
    .fall_pls   (mon_fall)
  );

  // Internal RC; its rising edges drive the divider, so tuning scales it.
  fail_safe_monitor_sync u_sync_rc (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .pin_async  (rc_clk_pin),
    .level_sync (),
    .rise_pls   (rc_rise),
    .fall_pls   ()
  );

  // Divide-by-64 sample clock.
  fail_safe_monitor_sample_div #(
    .DIV_W (`FAIL_SAFE_MONITOR_DIV_W)
  ) u_div (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .rc_rise  (rc_rise),
    .smp_rise (smp_rise),
    .smp_fall (smp_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Detection.
  ////////////////////////////////////////////////////////////////////////

  // The fuse gates monitoring, not the clock switching; the fuse word is static after reset.
  assign fuse_en = config_word_1_high[`FAIL_SAFE_MONITOR_FUSE_BIT];

  // Monitoring only in the monitor state on a checked source.
  assign mon_active = fuse_en & (st_r.fsm == ST_MONITOR)
                    & is_checked(st_r.sel);

  // A sample fall with the latch still set is a failure.
  assign clk_fail = mon_active & smp_fall & st_r.latch;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  ////////////////////////////////////////////////////////////////////////

  // Builds the next state from events of this cycle.
  always_comb begin
    st_nxt         = st_r;
    st_nxt.wdt_clr = 1'b0;
    st_nxt.wake    = 1'b0;

    // Latch: cleared when idle, cleared by sample rise, set by clock fall.
    if (!mon_active) begin
      st_nxt.latch = 1'b0;
    end else if (mon_fall) begin
      st_nxt.latch = 1'b1;
    end else if (smp_rise) begin
      st_nxt.latch = 1'b0;
    end

    // Flag: the hardware set wins over a software clear.
    if (clk_fail) begin
      st_nxt.flag = 1'b1;
    end else if (osc_fail_flag_clr) begin
      st_nxt.flag = 1'b0;
    end

    unique case (st_r.fsm)
      // Waiting for the primary; system runs on the internal block.
      ST_STARTUP: begin
        st_nxt.sel = SEL_INTERNAL;
        if (pm_entry) begin
          // New power-managed mode: drop the primary, take the register.
          st_nxt.prim_en = 1'b0;
          st_nxt.sel     = fail_safe_monitor_sel_t'(osc_ctrl_sel);
          st_nxt.fsm     = ST_MONITOR;
        end else if (startup_done || !is_crystal(primary_mode)) begin
          // Primary stable, or a mode with no start-up delay: monitor it.
          // The reset state always lands here, so non-crystal modes leave
          // on the first edge after release.
          st_nxt.sel = SEL_PRIMARY;
          st_nxt.fsm = ST_MONITOR;
        end
      end
      // Normal running with monitoring.
      ST_MONITOR: begin
        if (clk_fail) begin
          // Switch to internal; the control register is left alone.
          st_nxt.sel     = SEL_INTERNAL;
          st_nxt.fsm     = ST_FAILSAFE;
          st_nxt.wdt_clr = 1'b1;
          // Asleep with the interrupt enabled, the CPU resumes.
          st_nxt.wake = in_power_managed & osc_fail_irq_en;
        end else if (pm_entry) begin
          st_nxt.sel = fail_safe_monitor_sel_t'(osc_ctrl_sel);
        end else if (wake_from_sleep && is_crystal(primary_mode) &&
                     st_r.sel == SEL_PRIMARY) begin
          // Crystal wake: run internal until the timers expire.
          st_nxt.sel = SEL_INTERNAL;
          st_nxt.fsm = ST_STARTUP;
        end
      end
      // Fail-safe: internal clock, no automatic return.
      ST_FAILSAFE: begin
        st_nxt.sel = SEL_INTERNAL;
        if (pm_entry) begin
          // Sleep clears the condition and selects the register source.
          st_nxt.sel = fail_safe_monitor_sel_t'(osc_ctrl_sel);
          st_nxt.fsm = ST_MONITOR;
        end
      end
    endcase

    // Reset starts crystals with timers, other modes go straight on.
    if (srst) begin
      st_nxt.fsm     = is_crystal(primary_mode) ? ST_STARTUP : ST_MONITOR;
      st_nxt.sel     = is_crystal(primary_mode) ? SEL_INTERNAL : SEL_PRIMARY;
      st_nxt.prim_en = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.
  ////////////////////////////////////////////////////////////////////////

  // The reset value holds the internal clock; a cycle later the mode decides.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r.fsm     <= ST_STARTUP;
      st_r.sel     <= SEL_INTERNAL;
      st_r.latch   <= 1'b0;
      st_r.flag    <= 1'b0;
      st_r.wdt_clr <= 1'b0;
      st_r.wake    <= 1'b0;
      st_r.prim_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Mode decision lands one cycle after reset release.
  logic boot_r; // First cycle after reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.
  ////////////////////////////////////////////////////////////////////////

  // RC stays on for the monitor even if the watchdog is off.
  assign rc_run_en = fuse_en | watchdog_enable;

  assign sys_clk_sel      = st_r.sel;
  assign primary_osc_en   = st_r.prim_en;
  assign osc_fail_flag    = st_r.flag;
  assign watchdog_clear   = st_r.wdt_clr;
  assign pm_wake_req      = st_r.wake;
  assign fail_safe_active = (st_r.fsm == ST_FAILSAFE);

  // Ready only while the primary really drives the system clock.
  assign primary_ready_status = (st_r.sel == SEL_PRIMARY);

  // Flag placed at its bit; other bits belong elsewhere and read zero.
  always_comb begin
    peripheral_irq_flags_2 = 8'h00;
    peripheral_irq_flags_2[`FAIL_SAFE_MONITOR_FLAG_BIT] = st_r.flag;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.
  ////////////////////////////////////////////////////////////////////////

  // A failure sets the flag on the next edge.
  a_fail_sets_flag: assert property (@(posedge clk_sys) disable iff (srst)
    clk_fail |=> osc_fail_flag) else $error("fail flag not set");

  // A failure moves the clock to internal and enters fail-safe.
  a_fail_to_intl: assert property (@(posedge clk_sys) disable iff (srst)
    clk_fail |=> (sys_clk_sel == SEL_INTERNAL) && fail_safe_active)
    else $error("no switch on failure");

  // Watchdog clear is exactly the cycle after a failure.
  a_wdt_clear: assert property (@(posedge clk_sys) disable iff (srst)
    watchdog_clear == $past(clk_fail))
    else $error("watchdog clear mismatch");

  // Without the fuse no failure is ever seen.
  a_fuse_gates: assert property (@(posedge clk_sys) disable iff (srst)
    !config_word_1_high[`FAIL_SAFE_MONITOR_FUSE_BIT] |-> !clk_fail)
    else $error("failure with fuse off");

  // Fail-safe holds until a sleep entry.
  a_failsafe_hold: assert property (@(posedge clk_sys) disable iff (srst)
    fail_safe_active && !pm_entry |=> fail_safe_active)
    else $error("fail-safe left early");

  // Sleep in fail-safe takes the register source.
  a_sleep_exit: assert property (@(posedge clk_sys) disable iff (srst)
    fail_safe_active && pm_entry |=> !fail_safe_active
    && sys_clk_sel == $past(osc_ctrl_sel))
    else $error("sleep exit wrong");

  // Ready bit follows the actual source.
  a_ready_bit: assert property (@(posedge clk_sys) disable iff (srst)
    primary_ready_status == (sys_clk_sel == SEL_PRIMARY))
    else $error("ready bit wrong");

  // No failure while waiting for a crystal.
  a_no_start_fail: assert property (@(posedge clk_sys) disable iff (srst)
    st_r.fsm == ST_STARTUP |-> !clk_fail)
    else $error("failure during start-up");

  // Sleep entry while waiting turns the primary off.
  a_prim_off: assert property (@(posedge clk_sys) disable iff (srst)
    st_r.fsm == ST_STARTUP && pm_entry |=> !primary_osc_en)
    else $error("primary left on");

  // The internal source is never checked.
  a_intl_unchecked: assert property (@(posedge clk_sys) disable iff (srst)
    sys_clk_sel == SEL_INTERNAL |-> !mon_active)
    else $error("internal source checked");

  // The flag survives a clear in the cycle it is set.
  a_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
    clk_fail && osc_fail_flag_clr |=> osc_fail_flag)
    else $error("clear beat set");

  // Reset release on non-crystal mode monitors at once.
  a_direct_mon: assert property (@(posedge clk_sys)
    boot_r && !is_crystal(primary_mode) && !srst |=> st_r.fsm == ST_MONITOR)
    else $error("no direct monitoring");

  // Main scenarios.
  c_failure: cover property (@(posedge clk_sys) disable iff (srst) clk_fail);
  c_recover: cover property (@(posedge clk_sys) disable iff (srst)
    fail_safe_active && pm_entry);
  c_sleep_wake: cover property (@(posedge clk_sys) disable iff (srst)
    pm_wake_req);
  c_startup_done: cover property (@(posedge clk_sys) disable iff (srst)
    st_r.fsm == ST_STARTUP && startup_done);

endmodule // fail_safe_monitor_monitor
`default_nettype wire

// File: bench/fail_safe_monitor_osc_model.sv
// Behavioural model of the external clock source watched by the monitor.
// Assumes the bench starts and stops it; a stopped oscillator rests low.
`timescale 1ns/10ps
`default_nettype none
module fail_safe_monitor_osc_model #(
  parameter int HALF_NS = 25 // Half period at the fast rate.
) (
  input  wire logic run,     // Oscillator running when high.
  input  wire logic slow,    // Doubles the period when high.
  output logic      osc_pin  // Clock pin towards the device.
);
  //////////////////////////////////////////////////////////////////////////
  // Free-running toggle; a dead oscillator shows no edges at all.
  initial begin
    osc_pin = 1'h0;
    forever begin
      #(slow ? 2 * HALF_NS : HALF_NS);
      if (run) begin
        osc_pin = ~osc_pin;
      end else begin
        osc_pin = 1'h0;
      end
    end
  end
endmodule // fail_safe_monitor_osc_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench of the fail-safe clock monitor.
// Assumes the package is compiled first; clocks and pins come from here.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fail_safe_monitor_pkg::*;
  logic       clk_sys, srst, rc_pin, mon_pin, mon_run, mon_slow;
  logic [7:0] cfg, irqf;
  logic [2:0] mode;
  logic [1:0] ctl_sel, sel;
  logic       st_done, wake, pm_ent, in_pm, irq_en, flag_clr, wd_en;
  logic       rc_en, prim_en, ready, flag, wd_clr, fs_act, wake_req;
  int         failures, checks_done;

  fail_safe_monitor_monitor i_fail_safe_monitor_monitor (.clk_sys(clk_sys), .srst(srst), .config_word_1_high(cfg),
    .primary_mode(mode), .mon_clk_pin(mon_pin), .rc_clk_pin(rc_pin), .startup_done(st_done),
    .wake_from_sleep(wake), .pm_entry(pm_ent), .osc_ctrl_sel(ctl_sel),
    .in_power_managed(in_pm), .osc_fail_irq_en(irq_en), .osc_fail_flag_clr(flag_clr),
    .watchdog_enable(wd_en), .rc_run_en(rc_en), .sys_clk_sel(sel),
    .primary_osc_en(prim_en), .primary_ready_status(ready), .osc_fail_flag(flag),
    .peripheral_irq_flags_2(irqf), .watchdog_clear(wd_clr), .fail_safe_active(fs_act),
    .pm_wake_req(wake_req));
  fail_safe_monitor_osc_model i_fail_safe_monitor_osc_model (.run(mon_run), .slow(mon_slow), .osc_pin(mon_pin));

  //////////////////////////////////////////////////////////////////////////
  // System clock of 8 ns and an unrelated 40 ns internal RC clock.
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    rc_pin = 1'h0;
    forever #20 rc_pin = ~rc_pin;
  end

  //////////////////////////////////////////////////////////////////////////
  // Compare, count and report a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Reset for four cycles; outputs must show the safe start meanwhile.
  task automatic do_reset(input logic [2:0] m);
    mode = m;
    srst = 1'h1;
    cyc(4);
    chk(fs_act, 8'h00, "fail-safe in reset");
    chk(ready, 8'h00, "ready in reset");
    chk(flag, 8'h00, "flag in reset");
    srst = 1'h0;
    cyc(3);
  endtask
  // One-cycle pulse on a sleep-entry or clear input.
  task automatic pulse_pm();
    pm_ent = 1'h1;
    cyc(1);
    pm_ent = 1'h0;
    cyc(1);
  endtask
  task automatic clr_flag();
    flag_clr = 1'h1;
    cyc(1);
    flag_clr = 1'h0;
    cyc(1);
    chk(flag, 8'h00, "flag cleared");
    chk(irqf, 8'h00, "flag register cleared");
  endtask
  // Waits a bounded time for the watchdog clear pulse of a failure.
  task automatic wait_fail(input int lim, output bit seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge clk_sys);
      if (wd_clr === 1'h1) seen = 1'b1;
    end
  endtask
  task automatic expect_fail(input logic exp_wake);
    bit seen;
    wait_fail(1100, seen);
    chk(8'(seen), 8'h01, "failure detected");
    chk(flag, 8'h01, "fail flag");
    chk(irqf, 8'h80, "flag bit seven");
    chk(sel, SEL_INTERNAL, "switched to internal");
    chk(ready, 8'h00, "ready dropped");
    chk(fs_act, 8'h01, "fail-safe entered");
    chk(wake_req, 8'(exp_wake), "wake request");
    cyc(1);
    chk(wd_clr, 8'h00, "watchdog clear one cycle");
    chk(wake_req, 8'h00, "wake request one cycle");
  endtask
  task automatic expect_quiet();
    bit seen;
    wait_fail(1000, seen);
    chk(8'(seen), 8'h00, "no failure");
    chk(flag, 8'h00, "no flag");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Verdict; the only place where the run ends.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // The tests need about 7500 cycles; cut a hang at 40000.
  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence; inputs change on the falling edge.
  initial begin
    failures = 0;
    checks_done = 0;
    srst = 1'h1;
    cfg = 8'h00;
    mode = MD_EXT_CLOCK;
    mon_run = 1'h1;
    mon_slow = 1'h0;
    {st_done, wake, pm_ent, in_pm, irq_en, flag_clr, wd_en} = 7'h00;
    ctl_sel = SEL_PRIMARY;
    // Fuse clear: a running clock is never judged.
    do_reset(MD_EXT_CLOCK);
    chk(rc_en, 8'h00, "rc off");
    expect_quiet();
    wd_en = 1'h1;
    cyc(1);
    chk(rc_en, 8'h01, "rc for watchdog");
    wd_en = 1'h0;
    // Fuse set, external clock: monitoring starts at once.
    cfg = 8'h40;
    mon_run = 1'h0;
    do_reset(MD_EXT_CLOCK);
    chk(rc_en, 8'h01, "rc kept on");
    chk(sel, SEL_PRIMARY, "primary at once");
    chk(ready, 8'h01, "ready on primary");
    expect_quiet();
    mon_run = 1'h1;
    expect_fail(1'h0);
    clr_flag();
    cyc(400);
    chk(fs_act, 8'h01, "fail-safe held");
    // Sleep entry clears fail-safe; failure there with interrupt on.
    ctl_sel = SEL_SECONDARY;
    in_pm = 1'h1;
    irq_en = 1'h1;
    pulse_pm();
    chk(fs_act, 8'h00, "fail-safe left");
    chk(sel, SEL_SECONDARY, "source from control");
    mon_slow = 1'h1;
    expect_fail(1'h1);
    mon_slow = 1'h0;
    cyc(400);
    chk(sel, SEL_INTERNAL, "no automatic return");
    // Failure in sleep with the interrupt off.
    irq_en = 1'h0;
    pulse_pm();
    expect_fail(1'h0);
    cyc(400);
    chk(sel, SEL_INTERNAL, "stays internal");
    // Internal source selected: nothing is checked.
    clr_flag();
    ctl_sel = SEL_INTERNAL;
    pulse_pm();
    expect_quiet();
    in_pm = 1'h0;
    // Crystal mode waits for its start-up timers.
    do_reset(MD_STD_XTAL);
    chk(sel, SEL_INTERNAL, "internal during start-up");
    expect_quiet();
    st_done = 1'h1;
    cyc(3);
    chk(sel, SEL_PRIMARY, "primary after start-up");
    chk(ready, 8'h01, "ready after start-up");
    expect_fail(1'h0);
    // Reset out of fail-safe; primary never becomes ready.
    st_done = 1'h0;
    do_reset(MD_STD_XTAL);
    cyc(1000);
    chk(sel, SEL_INTERNAL, "internal while waiting");
    chk(ready, 8'h00, "not ready");
    // New sleep mode while waiting shuts the primary off.
    ctl_sel = SEL_SECONDARY;
    pulse_pm();
    chk(prim_en, 8'h00, "primary disabled");
    chk(sel, SEL_SECONDARY, "secondary chosen");
    do_reset(MD_STD_XTAL);
    st_done = 1'h1;
    cyc(3);
    st_done = 1'h0;
    wake = 1'h1;
    cyc(1);
    wake = 1'h0;
    cyc(2);
    chk(sel, SEL_INTERNAL, "wake restarts crystal");
    stop_test();
  end
endmodule // tb
`default_nettype wire
